// *** hdl/pipe_timing_pkg.sv ***
/*
  Shared constants and types for the instruction timing and fetch/execute
  pipeline control block. Assumes a single system clock domain.
*/
package pipe_timing_pkg;

  // ----------------------------------------------------------------
  // Widths and fields
  // ----------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int IMM_MSB = 7;
  localparam int TARGET_MSB = 11;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [15:0] INSTR_BUBBLE = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] PHASE_ONEHOT_RESET = 4'h1;
  // Slow oscillator tick once every 16 system clocks
  localparam logic [3:0] SLOW_DIV_LAST = 4'hf;
  localparam logic [3:0] DIV_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    phase_fetch  = 2'b00,
    phase_decode = 2'b01,
    phase_alu    = 2'b10,
    phase_commit = 2'b11
  } phase_t;

  typedef enum logic [3:0] {
    op_nop       = 4'h0,
    op_addi      = 4'h1,
    op_andi      = 4'h2,
    op_xori      = 4'h3,
    op_movi      = 4'h4,
    op_ext_add   = 4'h5,
    op_jump      = 4'h6,
    op_call      = 4'h7,
    op_skip_zero = 4'h8,
    op_pcl_load  = 4'h9
  } opcode_t;

  typedef struct packed {
    logic rd;
    logic [11:0] addr;
  } fetch_req_t;

  typedef struct packed {
    logic valid;
    logic idle;
    logic flushed;
    logic [3:0] op;
    logic [7:0] operand;
  } retire_t;

endpackage

// *** hdl/instruction_pipeline_timing.sv ***
/*
  Instruction-cycle timing and two-stage fetch/execute pipeline control of
  a small 8-bit core, with a minimal accumulator datapath.
  Assumes program memory answers fetch.addr combinationally, so that
  fetch_data is valid in the same cycle as the fetch pulse and onward.
*/
module instruction_pipeline_timing
  import pipe_timing_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Oscillator choice pin, high selects slow_internal_osc
  input wire logic slow_osc_select,
  // Program memory
  output fetch_req_t fetch,
  input wire logic [15:0] fetch_data,
  // Status
  output logic [3:0] four_phase_clocks,
  output logic [7:0] acc,
  output retire_t retire
);

  // ----------------------------------------------------------------
  // Oscillator selection and phase tick
  // ----------------------------------------------------------------
  logic sel_meta;
  logic sel_mid;
  logic sel_last;
  logic sel_slow;
  logic [3:0] div_count;
  logic next_sel_slow;
  logic [3:0] next_div_count;
  logic tick;

  always_comb begin
    next_sel_slow = sel_slow;
    // Only a settled pin value changes the source
    if (sel_mid == sel_last) begin
      next_sel_slow = sel_last;
    end
    next_div_count = (div_count == SLOW_DIV_LAST) ? DIV_RESET : 4'(div_count + 4'h1);
  end

  // Fast source ticks every clock, slow one through the divider
  assign tick = sel_slow ? (div_count == SLOW_DIV_LAST) : 1'b1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_meta <= 1'b0;
      sel_mid <= 1'b0;
      sel_last <= 1'b0;
      sel_slow <= 1'b0;
      div_count <= DIV_RESET;
    end else begin
      sel_meta <= slow_osc_select;
      sel_mid <= sel_meta;
      sel_last <= sel_mid;
      sel_slow <= next_sel_slow;
      div_count <= next_div_count;
    end
  end

  // ----------------------------------------------------------------
  // Phase generator, fetch and execute
  // ----------------------------------------------------------------
  phase_t phase;
  logic [11:0] pc;
  logic [15:0] prefetch;
  logic [15:0] exec_word;
  logic hold;
  logic flush_pending;
  opcode_t dec_op;
  logic [7:0] alu_result;

  phase_t next_phase;
  logic [3:0] next_phase_oh;
  logic [11:0] next_pc;
  fetch_req_t next_fetch;
  logic [15:0] next_prefetch;
  logic [15:0] next_exec_word;
  logic next_hold;
  logic next_flush_pending;
  opcode_t next_dec_op;
  logic [7:0] next_alu_result;
  logic [7:0] next_acc;
  retire_t next_retire;

  logic [7:0] imm;
  opcode_t exec_op;
  logic do_flush;

  assign imm = exec_word[IMM_MSB:0];
  assign exec_op = opcode_t'(exec_word[OPC_MSB:OPC_LSB]);

  always_comb begin
    next_phase = phase;
    next_phase_oh = four_phase_clocks;
    next_pc = pc;
    next_fetch = fetch;
    next_fetch.rd = 1'b0;
    next_prefetch = prefetch;
    next_exec_word = exec_word;
    next_hold = hold;
    next_flush_pending = flush_pending;
    next_dec_op = dec_op;
    next_alu_result = alu_result;
    next_acc = acc;
    next_retire = retire;
    next_retire.valid = 1'b0;
    do_flush = 1'b0;
    if (tick) begin
      // One-hot rotation keeps the phases non-overlapping
      next_phase = phase_t'(2'(phase + 2'b01));
      next_phase_oh = {four_phase_clocks[2:0], four_phase_clocks[3]};
      unique case (phase)
        phase_fetch: begin
          // No fetch while an extended instruction holds the pipe
          if (!hold) begin
            next_fetch.rd = 1'b1;
            next_fetch.addr = pc;
            next_pc = 12'(pc + 12'h001);
          end
        end
        phase_decode: begin
          if (!hold) begin
            next_prefetch = fetch_data;
          end
          next_dec_op = exec_op;
        end
        phase_alu: begin
          // 8-bit results, carries dropped
          unique case (dec_op)
            op_addi, op_ext_add: next_alu_result = 8'(acc + imm);
            op_andi: next_alu_result = acc & imm;
            op_xori: next_alu_result = acc ^ imm;
            op_movi: next_alu_result = imm;
            default: next_alu_result = acc;
          endcase
        end
        phase_commit: begin
          next_retire.valid = 1'b1;
          next_retire.idle = flush_pending;
          next_retire.flushed = 1'b0;
          next_retire.op = exec_word[OPC_MSB:OPC_LSB];
          next_retire.operand = imm;
          next_flush_pending = 1'b0;
          next_hold = 1'b0;
          next_exec_word = prefetch;
          unique case (exec_op)
            op_addi, op_andi, op_xori, op_movi: begin
              next_acc = alu_result;
            end
            op_ext_add: begin
              // First pass only occupies the cycle
              if (!hold) begin
                next_hold = 1'b1;
                next_exec_word = exec_word;
                next_retire.valid = 1'b0;
              end else begin
                next_acc = alu_result;
              end
            end
            op_jump, op_call: begin
              // Target known now, taken by the next cycle's fetch
              next_pc = exec_word[TARGET_MSB:0];
              do_flush = 1'b1;
            end
            op_skip_zero: begin
              if (acc == ACC_RESET) begin
                do_flush = 1'b1;
              end
            end
            op_pcl_load: begin
              // Page bits kept, so the jump stays in this page
              next_pc = {pc[11:8], acc};
              do_flush = 1'b1;
            end
            default: begin
            end
          endcase
          if (do_flush) begin
            // Prefetched word is dropped and a bubble runs instead
            next_exec_word = INSTR_BUBBLE;
            next_flush_pending = 1'b1;
            next_retire.flushed = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Restart at the first phase with an empty pipe
      phase <= phase_fetch;
      four_phase_clocks <= PHASE_ONEHOT_RESET;
      pc <= RESET_VECTOR;
      fetch <= '0;
      prefetch <= INSTR_BUBBLE;
      exec_word <= INSTR_BUBBLE;
      hold <= 1'b0;
      flush_pending <= 1'b0;
      dec_op <= op_nop;
      alu_result <= ACC_RESET;
      acc <= ACC_RESET;
      retire <= '0;
    end else begin
      phase <= next_phase;
      four_phase_clocks <= next_phase_oh;
      pc <= next_pc;
      fetch <= next_fetch;
      prefetch <= next_prefetch;
      exec_word <= next_exec_word;
      hold <= next_hold;
      flush_pending <= next_flush_pending;
      dec_op <= next_dec_op;
      alu_result <= next_alu_result;
      acc <= next_acc;
      retire <= next_retire;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_flush_fast;
    (retire.valid && retire.flushed && !sel_slow) ##1 (!sel_slow) [*3];
  endsequence

  // Source must have been slow for a cycle already, or the last fast step counts
  sequence s_slow_step;
    sel_slow && $past(sel_slow) && $changed(four_phase_clocks);
  endsequence

  sequence s_branch_retire;
    retire.valid && retire.flushed && !sel_slow && (retire.op == op_jump || retire.op == op_call);
  endsequence

  a_slow_rate: assert property (
    s_slow_step |=> (!$changed(four_phase_clocks) || !sel_slow) [*8])
    else $error("slow source advanced phases too fast");

  a_phase_onehot: assert property (
    $onehot(four_phase_clocks) && (four_phase_clocks == (4'h1 << phase)))
    else $error("phase clocks overlap or disagree with phase");

  a_fetch_phase: assert property (
    fetch.rd |-> four_phase_clocks == 4'h2 && pc == 12'(fetch.addr + 12'h001))
    else $error("fetch outside first phase or counter not incremented");

  a_exec_phase: assert property (
    $changed(acc) |-> $past(phase) == phase_commit && $past(tick))
    else $error("accumulator written outside last phase");

  a_retire_cycle: assert property (
    retire.valid |-> four_phase_clocks == 4'h1)
    else $error("retire not at end of instruction cycle");

  a_overlap_fetch: assert property (
    retire.valid && !sel_slow |=> fetch.rd && fetch.addr == $past(pc))
    else $error("next fetch did not overlap the retired instruction");

  a_branch_fetch: assert property (
    s_branch_retire |=> fetch.rd && fetch.addr[7:0] == $past(retire.operand))
    else $error("branch did not fetch from its target");

  a_skip_discard: assert property (
    retire.valid && retire.flushed && retire.op == op_skip_zero |-> exec_word == INSTR_BUBBLE && flush_pending)
    else $error("successful skip kept the prefetched word");

  a_ext_two: assert property (
    retire.valid && retire.op == op_ext_add && !retire.idle |-> $past(hold) && !hold)
    else $error("extended instruction did not take two cycles");

  a_flush_idle: assert property (
    s_flush_fast |=> retire.valid && retire.idle)
    else $error("no idle cycle after counter change");

  a_alu_add: assert property (
    retire.valid && retire.op == op_addi && !retire.idle |-> acc == 8'($past(acc) + retire.operand))
    else $error("8-bit add result wrong");

  a_pcl_page: assert property (
    retire.valid && retire.op == op_pcl_load |-> pc[7:0] == acc && pc[11:8] == $past(pc[11:8]))
    else $error("low byte load left its page");

  a_reset_restart: assert property (
    $rose(rst_n) |-> four_phase_clocks == PHASE_ONEHOT_RESET && exec_word == INSTR_BUBBLE && !fetch.rd)
    else $error("reset did not restart pipeline");

endmodule

// *** bench/prog_mem.sv ***
/*
  Program memory model for the pipeline timing block.
  Assumes the fetched word is sampled by the end of the decode phase.
*/
module prog_mem
  import pipe_timing_pkg::*;
(
  // Fetch side
  input wire logic [11:0] addr,
  input wire logic [3:0] phases,
  output logic [15:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rom [0:63];
  // Word is valid only in the fetch window; inverted outside it so
  // a late sample never sees a stale match
  always_comb begin
    data = rom[addr[5:0]];
    if (!phases[1]) begin
      data = ~data;
    end
  end
endmodule

// *** bench/tb_top.sv ***
/*
  Self-checking bench for the pipeline timing block.
  Assumes prog_mem as far side and a 10 MHz system clock.
*/
module tb_top;
  import pipe_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] gap;
    logic idle;
    logic fl;
    logic [3:0] op;
    logic ck;
    logic [7:0] acc;
  } exp_t;
  // Address and word of each program location
  localparam logic [27:0] IMG [15] = '{28'h000_40f0, 28'h001_1020, 28'h002_203c,
    28'h003_3010, 28'h004_8000, 28'h005_4077, 28'h006_6020, 28'h007_4099, 28'h020_7030,
    28'h030_5001, 28'h031_4008, 28'h032_9000, 28'h033_4055, 28'h008_403a, 28'h009_8000};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_osc_select = 1'b0;
  fetch_req_t fetch;
  logic [15:0] fetch_data;
  logic [3:0] four_phase_clocks;
  logic [7:0] acc;
  retire_t retire;
  int errors = 0;
  int checks_done = 0;
  exp_t q[$];

  instruction_pipeline_timing instruction_pipeline_timing_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .slow_osc_select(slow_osc_select), .fetch(fetch), .fetch_data(fetch_data),
    .four_phase_clocks(four_phase_clocks), .acc(acc), .retire(retire));
  prog_mem prog_mem_inst (.addr(fetch.addr), .phases(four_phase_clocks), .data(fetch_data));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(negedge sys_clk) rst_n = 1'b0;
    repeat (n) @(negedge sys_clk);
    chk(four_phase_clocks, 4'h1);
    chk({acc, 7'h00, fetch.rd}, 16'h0000);
    rst_n = 1'b1;
  endtask

  task automatic ex(input int g, input bit idl, input bit fl, input int op, input bit ck, input int a);
    q.push_back('{g[3:0], idl, fl, op[3:0], ck, a[7:0]});
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_phases();
    int i;
    i = 0;
    while (fetch.rd !== 1'b1 && i < 4) begin
      @(negedge sys_clk);
      i++;
    end
    chk(fetch.addr, 12'h000);
    for (i = 0; i < 5; i++) begin
      chk(four_phase_clocks, 4'h1 << ((i + 1) % 4));
      chk(fetch.rd, (i % 4) == 0);
      @(negedge sys_clk);
    end
    chk(fetch.addr, 12'h001);
  endtask

  // Loaded before the first reset so no fetch ever returns unknown words
  task automatic load_rom();
    for (int i = 0; i < 64; i++) begin
      prog_mem_inst.rom[i] = 16'h0000;
    end
    for (int i = 0; i < 15; i++) begin
      prog_mem_inst.rom[IMG[i][21:16]] = IMG[i][15:0];
    end
  endtask

  task automatic t_program();
    int n, cyc, last;
    exp_t e;
    ex(4, 0, 0, 4, 1, 'hf0);
    ex(4, 0, 0, 1, 1, 'h10);
    ex(4, 0, 0, 2, 1, 'h10);
    ex(4, 0, 0, 3, 1, 'h00);
    ex(4, 0, 1, 8, 0, 0);
    ex(4, 1, 0, 0, 0, 0);
    ex(4, 0, 1, 6, 0, 0);
    ex(4, 1, 0, 0, 0, 0);
    ex(4, 0, 1, 7, 0, 0);
    ex(4, 1, 0, 0, 0, 0);
    ex(8, 0, 0, 5, 1, 'h01);
    ex(4, 0, 0, 4, 1, 'h08);
    ex(4, 0, 1, 9, 0, 0);
    ex(4, 1, 0, 0, 0, 0);
    ex(4, 0, 0, 4, 1, 'h3a);
    ex(4, 0, 0, 8, 1, 'h3a);
    ex(4, 0, 0, 0, 0, 0);
    do_reset(2);
    n = 0;
    cyc = 0;
    last = 0;
    // First retire after reset is the start-up bubble
    while (n <= q.size() && cyc < 200) begin
      @(negedge sys_clk);
      cyc++;
      if (retire.valid === 1'b1) begin
        if (n > 0) begin
          e = q[n - 1];
          chk(16'(cyc - last), 16'(e.gap));
          chk(retire.idle, e.idle);
          if (!e.idle) begin
            chk(retire.flushed, e.fl);
            chk(retire.op, e.op);
          end else begin
            chk({retire.op, retire.operand}, 16'h0000);
          end
          // A move's operand is the value it loads
          if (e.ck && e.op == 4'h4) begin
            chk(retire.operand, e.acc);
          end
          if (e.ck) begin
            chk(acc, e.acc);
          end
        end
        last = cyc;
        n++;
      end
    end
    chk(16'(n), 16'(q.size() + 1));
  endtask

  task automatic t_slow();
    int i, c;
    logic [3:0] p;
    slow_osc_select = 1'b1;
    do_reset(2);
    repeat (8) @(negedge sys_clk);
    for (i = 0; i < 3; i++) begin
      p = four_phase_clocks;
      c = 0;
      while (four_phase_clocks === p && c < 40) begin
        @(negedge sys_clk);
        c++;
      end
      if (i > 0) begin
        chk(16'(c), 16'h0010);
        chk(four_phase_clocks, {p[2:0], p[3]});
      end
    end
    slow_osc_select = 1'b0;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    load_rom();
    do_reset(20);
    t_phases();
    t_program();
    do_reset(2);
    t_phases();
    t_slow();
    complete_run();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
endmodule
